/* logic/clkgen_consts.vh */
// Register map, field positions, reset values and timing counts of the clock generator control
// Included by the top control module of the block only; definitions only
`ifndef CLKGEN_CONSTS_VH
`define CLKGEN_CONSTS_VH

`define REG_SPI_CFG        8'h00
`define REG_CAL_SYNC       8'h01
`define REG_POWER_DOWN     8'h02
`define REG_CH1_RATIO      8'h14
`define REG_CH1_DRV        8'h15
`define REG_CH2_RATIO      8'h16
`define REG_CH2_DRV        8'h17
`define REG_CH3_RATIO      8'h18
`define REG_CH3_DRV        8'h19
`define REG_CH4_RATIO      8'h1A
`define REG_CH4_DRV        8'h1B
`define REG_LOCK_THR       8'h1D
`define REG_LOCK_ERR_LO    8'h1E
`define REG_LOCK_ERR_HI    8'h1F
`define REG_VCO_DIV_A      8'h20
`define REG_VCO_DIV_B      8'h21
`define REG_PRESCALER      8'h22
`define REG_LOOP_RATIO     8'h23
`define REG_LOOP_RESET     8'h24
`define REG_STATUS         8'h30

`define BIT_DIV_RESET      0
`define BIT_SOFT_RST_A     7
`define BIT_SOFT_RST_B     1
`define BIT_CAL_START      2
`define BIT_SYNC_START     1
`define BIT_TERM_ON        3
`define BIT_DRIVER_ON      2
`define SWING_HI           5
`define SWING_LO           4
`define RATIO_HI           4
`define RATIO_LO           3
`define PRESC_HI           3
`define PRESC_LO           2
`define THR_HI             3
`define THR_LO             1
`define BIT_ERR_UNIT       3
`define SLEEP_CODE         2'h3

`define RST_DRV            8'h04
`define RST_CH_RATIO       8'h01
`define RST_LOOP_RATIO     8'h0F
`define RST_ZERO           8'h00

`define WAIT_TIME_MS       2000
`define CLK_PERIOD_NS      10
`define WAIT_CYCLES        (`WAIT_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define TOGGLE_DELAY_NS    500
`define TOGGLE_CYCLES      (`TOGGLE_DELAY_NS / `CLK_PERIOD_NS)
`define CAL_CYCLES         16

`endif

/* logic/half_step_divider.v */
// Divider by 2, 2.5, 3 or 3.5 selected by a two-bit code, with a restart input
// Assumes the input clock is represented by a one-cycle enable on clk
`timescale 1ns/10ps
module half_step_divider (
   input  wire       clk,
   input  wire       nrst,
   input  wire       tick_in,
   input  wire       restart,
   input  wire [1:0] ratio_code,
   output reg        tick_out
);
   // Counting in half input periods: ratio 2+code/2 spans 4+code half steps
   reg  [2:0] half_count;
   reg  [2:0] next_half_count;
   // One spare bit: at ratio 3.5 the sum reaches 8 and would wrap in three bits
   wire [3:0] span     = 4'h4 + {2'b00, ratio_code};
   wire [3:0] half_sum = {1'b0, half_count} + 4'h2;
   wire       wrap     = half_sum >= span;

   always @* begin
      next_half_count = half_count;
      if (tick_in) begin
         if (wrap)
            next_half_count = half_sum[2:0] - span[2:0];
         else
            next_half_count = half_sum[2:0];
      end
   end

   always @(posedge clk) begin
      if (!nrst || restart) begin
         half_count <= 3'h0;
         tick_out   <= 1'b0;
      end else begin
         half_count <= next_half_count;
         tick_out   <= tick_in && wrap;
      end
   end
endmodule

/* logic/ratio_divider.v */
// Eight-bit integer divider, ratio 1 to 255, zero stops it
// Assumes the input clock is represented by a one-cycle enable on clk
`timescale 1ns/10ps
module ratio_divider #(
   parameter WIDTH = 8
) (
   input  wire             clk,
   input  wire             nrst,
   input  wire             tick_in,
   input  wire             restart,
   input  wire [WIDTH-1:0] ratio,
   output reg              tick_out
);
   reg [WIDTH-1:0] count;

   always @(posedge clk) begin
      if (!nrst || restart || ratio == {WIDTH{1'b0}}) begin
         count    <= {WIDTH{1'b0}};
         tick_out <= 1'b0;
      end else if (tick_in) begin
         if (count + 1'b1 >= ratio) begin
            count    <= {WIDTH{1'b0}};
            tick_out <= 1'b1;
         end else begin
            count    <= count + 1'b1;
            tick_out <= 1'b0;
         end
      end else begin
         tick_out <= 1'b0;
      end
   end
endmodule

/* logic/clkgen_control.v */
// Digital control of a PLL clock generator: dividers, sync, lock detect, resets, sleep
// Assumes a register port on clk and the oscillator and reference as one-cycle enables on clk
`timescale 1ns/10ps
`include "clkgen_consts.vh"
module clkgen_control #(
   parameter WAIT_CYCLES = `WAIT_CYCLES,
   parameter CH_COUNT    = 4
) (
   input  wire        clk,
   input  wire        nrst,
   input  wire        por,
   input  wire [7:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [7:0]  rdata,
   input  wire        osc_tick,
   input  wire        ref_tick,
   input  wire        ref_present,
   output wire        pd_feedback_tick,
   output wire [3:0]  out_tick,
   output wire [3:0]  driver_on,
   output wire [3:0]  driver_termination_on,
   output wire [7:0]  differential_swing,
   output wire        lock_output_pin,
   output wire        sleep_active,
   output reg         cal_busy
);
   // ************************************
   // Register storage
   // ************************************
   reg  [7:0] spi_cfg;
   reg  [7:0] cal_ctrl;
   reg  [1:0] power_mode;
   reg  [7:0] ch_ratio [0:3];
   reg  [7:0] ch_drv   [0:3];
   reg  [2:0] lock_thr;
   reg  [1:0] vco_a_code;
   reg  [1:0] vco_b_code;
   reg  [1:0] presc_code;
   reg  [7:0] loop_ratio;
   reg        soft_pending;
   reg        soft_reset;
   reg        rst_vco_a;
   reg        rst_vco_b;
   reg        rst_presc;
   reg        rst_loop;
   reg  [3:0] rst_ch;
   integer    i;

   // Register restore: reset pin, por or soft reset, the latter sparing 0x000 and 0x001
   wire defaults_now = !nrst || por || soft_reset;

   function is_ch_reg;
      input [7:0] a;
      input [7:0] base;
      begin
         is_ch_reg = (a >= base) && (a <= base + 8'h06) && (a[0] == base[0]);
      end
   endfunction

   function [1:0] ch_index;
      input [7:0] a;
      begin
         ch_index = a[2:1] - 2'h2;
      end
   endfunction

   // ************************************
   // Soft reset sequencing
   // ************************************
   // The soft reset only completes on the next register access, like the extra serial clock
   always @(posedge clk) begin
      if (!nrst || por) begin
         soft_pending <= 1'b0;
         soft_reset   <= 1'b0;
         spi_cfg      <= `RST_ZERO;
      end else begin
         soft_reset <= 1'b0;
         if (wr && addr == `REG_SPI_CFG) begin
            spi_cfg <= wdata & ~(8'h82);
            if (wdata[`BIT_SOFT_RST_A] && wdata[`BIT_SOFT_RST_B])
               soft_pending <= 1'b1;
         end else if (soft_pending && (wr || rd)) begin
            soft_pending <= 1'b0;
            soft_reset   <= 1'b1;
         end
      end
   end

   // ************************************
   // Configuration registers
   // ************************************
   always @(posedge clk) begin
      rst_vco_a <= 1'b0;
      rst_vco_b <= 1'b0;
      rst_presc <= 1'b0;
      rst_loop  <= 1'b0;
      rst_ch    <= 4'h0;
      if (defaults_now) begin
         power_mode <= 2'h0;
         lock_thr   <= 3'h0;
         vco_a_code <= 2'h0;
         vco_b_code <= 2'h0;
         presc_code <= 2'h0;
         loop_ratio <= `RST_LOOP_RATIO;
         for (i = 0; i < CH_COUNT; i = i + 1) begin
            ch_ratio[i] <= `RST_CH_RATIO;
            ch_drv[i]   <= `RST_DRV;
         end
      end else if (wr && !soft_pending) begin
         if (addr == `REG_POWER_DOWN)
            power_mode <= wdata[1:0];
         if (addr == `REG_LOCK_THR)
            lock_thr <= wdata[`THR_HI:`THR_LO];
         if (addr == `REG_VCO_DIV_A) begin
            vco_a_code <= wdata[`RATIO_HI:`RATIO_LO];
            rst_vco_a  <= wdata[`BIT_DIV_RESET];
         end
         if (addr == `REG_VCO_DIV_B) begin
            vco_b_code <= wdata[`RATIO_HI:`RATIO_LO];
            rst_vco_b  <= wdata[`BIT_DIV_RESET];
         end
         if (addr == `REG_PRESCALER) begin
            presc_code <= wdata[`PRESC_HI:`PRESC_LO];
            rst_presc  <= wdata[`BIT_DIV_RESET];
         end
         if (addr == `REG_LOOP_RATIO)
            loop_ratio <= wdata;
         if (addr == `REG_LOOP_RESET)
            rst_loop <= wdata[`BIT_DIV_RESET];
         if (is_ch_reg(addr, `REG_CH1_RATIO))
            ch_ratio[ch_index(addr)] <= wdata;
         if (is_ch_reg(addr, `REG_CH1_DRV)) begin
            ch_drv[ch_index(addr)] <= wdata & 8'hFE;
            rst_ch[ch_index(addr)] <= wdata[`BIT_DIV_RESET];
         end
      end
   end

   // ************************************
   // Wait timer and calibration
   // ************************************
   // Timer counts only after power-on, so pin and soft resets skip the wait
   reg [31:0] wait_count;
   reg        wait_done;
   reg        cal_held;
   reg [7:0]  cal_count;
   reg        sync_pulse;
   reg [7:0]  toggle_count;
   reg        outputs_live;

   always @(posedge clk) begin
      if (por) begin
         wait_count <= 32'h0;
         wait_done  <= 1'b0;
      end else if (!wait_done) begin
         if (wait_count + 32'h1 >= WAIT_CYCLES)
            wait_done <= 1'b1;
         wait_count <= wait_count + 32'h1;
      end
   end

   always @(posedge clk) begin
      if (!nrst || por) begin
         cal_ctrl     <= `RST_ZERO;
         cal_held     <= 1'b0;
         cal_busy     <= 1'b0;
         cal_count    <= 8'h0;
         sync_pulse   <= 1'b0;
         toggle_count <= 8'h0;
         outputs_live <= 1'b0;
      end else begin
         sync_pulse <= 1'b0;
         if (wr && addr == `REG_CAL_SYNC) begin
            cal_ctrl <= wdata & ~(8'h06);
            if (wdata[`BIT_CAL_START])
               cal_held <= 1'b1;
            if (wdata[`BIT_SYNC_START])
               sync_pulse <= 1'b1;
         end
         if (cal_held && wait_done && ref_present && !cal_busy) begin
            // A request written in the launch cycle stays queued for the next run
            cal_held  <= wr && addr == `REG_CAL_SYNC && wdata[`BIT_CAL_START];
            cal_busy  <= 1'b1;
            cal_count <= 8'h0;
         end else if (cal_busy) begin
            if (cal_count + 8'h1 >= `CAL_CYCLES) begin
               cal_busy     <= 1'b0;
               sync_pulse   <= 1'b1;
               toggle_count <= 8'h0;
            end
            cal_count <= cal_count + 8'h1;
         end
         if (sync_pulse && !outputs_live)
            toggle_count <= 8'h1;
         else if (toggle_count != 8'h0) begin
            if (toggle_count >= `TOGGLE_CYCLES)
               outputs_live <= 1'b1;
            else
               toggle_count <= toggle_count + 8'h1;
         end
      end
   end

   // ************************************
   // Divider chain
   // ************************************
   wire sleeping = power_mode == `SLEEP_CODE;
   wire run_osc  = osc_tick && !sleeping;
   wire presc_tick;
   wire vco_a_tick;
   wire vco_b_tick;

   half_step_divider u_presc (
      .clk        (clk),
      .nrst       (nrst),
      .tick_in    (run_osc),
      .restart    (rst_presc || sync_pulse),
      .ratio_code (presc_code),
      .tick_out   (presc_tick)
   );

   ratio_divider #(.WIDTH(8)) u_loop (
      .clk      (clk),
      .nrst     (nrst),
      .tick_in  (presc_tick),
      .restart  (rst_loop || sync_pulse),
      .ratio    (loop_ratio),
      .tick_out (pd_feedback_tick)
   );

   half_step_divider u_vco_a (
      .clk        (clk),
      .nrst       (nrst),
      .tick_in    (run_osc),
      .restart    (rst_vco_a || sync_pulse || sleeping),
      .ratio_code (vco_a_code),
      .tick_out   (vco_a_tick)
   );

   half_step_divider u_vco_b (
      .clk        (clk),
      .nrst       (nrst),
      .tick_in    (run_osc),
      .restart    (rst_vco_b || sync_pulse || sleeping),
      .ratio_code (vco_b_code),
      .tick_out   (vco_b_tick)
   );

   // Channels one and two hang off divider A, three and four off divider B
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_ch
         wire ch_src = (g < 2) ? vco_a_tick : vco_b_tick;
         ratio_divider #(.WIDTH(8)) u_ch (
            .clk      (clk),
            .nrst     (nrst),
            .tick_in  (ch_src && outputs_live && ch_drv[g][`BIT_DRIVER_ON] && !sleeping),
            .restart  (rst_ch[g] || sync_pulse),
            .ratio    (ch_ratio[g]),
            .tick_out (out_tick[g])
         );
         assign driver_on[g]             = ch_drv[g][`BIT_DRIVER_ON] && !sleeping;
         assign driver_termination_on[g] = ch_drv[g][`BIT_TERM_ON];
         assign differential_swing[2*g+1:2*g] = ch_drv[g][`SWING_HI:`SWING_LO];
      end
   endgenerate

   // ************************************
   // Lock detector
   // ************************************
   // Counts feedback against reference over a window of 1024 reference ticks
   reg  [10:0] ref_win;
   reg  [11:0] fb_count;
   reg  [9:0]  err_mag;
   reg         err_ppm;
   reg         locked;
   wire [11:0] diff = (fb_count > 12'd1024) ? fb_count - 12'd1024 : 12'd1024 - fb_count;

   // Thresholds in error counts rise with code; zero code is the tightest
   function [9:0] thr_limit;
      input [2:0] code;
      begin
         thr_limit = 10'h1 << code;
      end
   endfunction

   always @(posedge clk) begin
      if (!nrst || sleeping) begin
         ref_win  <= 11'h0;
         fb_count <= 12'h0;
         err_mag  <= 10'h0;
         err_ppm  <= 1'b0;
         locked   <= 1'b0;
      end else begin
         if (ref_tick && ref_win == 11'd1023) begin
            ref_win  <= 11'h0;
            fb_count <= {11'h0, pd_feedback_tick};
            err_mag  <= (diff > 12'h3FF) ? 10'h3FF : diff[9:0];
            err_ppm  <= 1'b1;
            locked   <= diff[9:0] < thr_limit(lock_thr) && diff < 12'h400;
         end else begin
            if (ref_tick)
               ref_win <= ref_win + 11'h1;
            if (pd_feedback_tick && fb_count != 12'hFFF)
               fb_count <= fb_count + 12'h1;
         end
      end
   end

   assign lock_output_pin = locked;
   assign sleep_active    = sleeping;

   // ************************************
   // Read port
   // ************************************
   always @(posedge clk) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `REG_SPI_CFG:     rdata <= spi_cfg;
            `REG_CAL_SYNC:    rdata <= cal_ctrl;
            `REG_POWER_DOWN:  rdata <= {6'h0, power_mode};
            `REG_CH1_RATIO:   rdata <= ch_ratio[0];
            `REG_CH1_DRV:     rdata <= ch_drv[0];
            `REG_CH2_RATIO:   rdata <= ch_ratio[1];
            `REG_CH2_DRV:     rdata <= ch_drv[1];
            `REG_CH3_RATIO:   rdata <= ch_ratio[2];
            `REG_CH3_DRV:     rdata <= ch_drv[2];
            `REG_CH4_RATIO:   rdata <= ch_ratio[3];
            `REG_CH4_DRV:     rdata <= ch_drv[3];
            `REG_LOCK_THR:    rdata <= {4'h0, lock_thr, 1'b0};
            `REG_LOCK_ERR_LO: rdata <= err_mag[7:0];
            `REG_LOCK_ERR_HI: rdata <= {4'h0, err_ppm, 1'b0, err_mag[9:8]};
            `REG_VCO_DIV_A:   rdata <= {3'h0, vco_a_code, 3'h0};
            `REG_VCO_DIV_B:   rdata <= {3'h0, vco_b_code, 3'h0};
            `REG_PRESCALER:   rdata <= {4'h0, presc_code, 2'h0};
            `REG_LOOP_RATIO:  rdata <= loop_ratio;
            `REG_LOOP_RESET:  rdata <= 8'h00;
            `REG_STATUS:      rdata <= {4'h0, outputs_live, wait_done, cal_busy, locked};
            default:          rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

/* dv/clkgen_control_assertions.sv */
// Concurrent checks on the ports of the clock generator control block
// Assumes one clock, synchronous active-low reset and a por pulse at start
`timescale 1ns/10ps
module clkgen_control_assertions #(
   parameter WAIT_CYCLES = 20
) (
   input logic       clk,
   input logic       nrst,
   input logic       por,
   input logic [7:0] addr,
   input logic [7:0] wdata,
   input logic       wr,
   input logic       rd,
   input logic [7:0] rdata,
   input logic       osc_tick,
   input logic       ref_tick,
   input logic       ref_present,
   input logic       pd_feedback_tick,
   input logic [3:0] out_tick,
   input logic [3:0] driver_on,
   input logic [3:0] driver_termination_on,
   input logic [7:0] differential_swing,
   input logic       lock_output_pin,
   input logic       sleep_active,
   input logic       cal_busy
);
   // ****************
   // Helper state
   // ****************
   logic [31:0] since_por;
   logic [4:0]  busy_len;
   logic [2:0]  zero_age;
   logic        ch2_zero;
   // Wait timer reference; nrst must not restart it, only por does
   always @(posedge clk) begin
      if (por) since_por <= 32'h0;
      else if (since_por != 32'hFFFFFFFF) since_por <= since_por + 32'h1;
   end
   always @(posedge clk) begin
      if (!nrst) begin
         busy_len <= 5'h00;
         zero_age <= 3'h0;
         ch2_zero <= 1'b0;
      end else begin
         busy_len <= cal_busy ? busy_len + 5'h01 : 5'h00;
         if (wr && addr == 8'h16) begin
            zero_age <= 3'h0;
            ch2_zero <= (wdata == 8'h00);
         end else if (zero_age != 3'h7) zero_age <= zero_age + 3'h1;
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence ratio_write;
      wr && addr == 8'h14;
   endsequence
   sequence ratio_read;
      rd && addr == 8'h14;
   endsequence
   ratio_readback_a: assert property (ratio_write ##2 ratio_read |=> rdata == $past(wdata, 3))
      else $error("channel ratio read back differs from write");
   reset_bit_clear_a: assert property (rd && addr == 8'h15 |=> rdata[0] == 1'b0)
      else $error("divider reset bit reads as set");
   ch1_driver_cfg_a: assert property (wr && addr == 8'h15 |=>
      driver_termination_on[0] == $past(wdata[3]) && differential_swing[1:0] == $past(wdata[5:4]))
      else $error("channel one driver settings not applied");
   sleep_entry_a: assert property (wr && addr == 8'h02 && wdata[1:0] == 2'h3 |=> sleep_active)
      else $error("sleep code did not enter sleep");
   sleep_outputs_off_a: assert property (sleep_active[*2] |-> driver_on == 4'h0 && out_tick == 4'h0)
      else $error("outputs active during sleep");
   cal_length_a: assert property ($fell(cal_busy) |-> busy_len == 5'h10)
      else $error("calibration length wrong");
   cal_wait_a: assert property (cal_busy |-> since_por >= WAIT_CYCLES)
      else $error("calibration ran before wait timer expired");
   zero_ratio_stop_a: assert property (ch2_zero && zero_age > 3'h3 |-> !out_tick[1])
      else $error("channel two ticks with ratio zero");
endmodule

bind clkgen_control clkgen_control_assertions #(.WAIT_CYCLES(WAIT_CYCLES))
   clkgen_control_assertions_inst (.clk(clk), .nrst(nrst), .por(por), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_tick(osc_tick), .ref_tick(ref_tick),
   .ref_present(ref_present), .pd_feedback_tick(pd_feedback_tick), .out_tick(out_tick),
   .driver_on(driver_on), .driver_termination_on(driver_termination_on),
   .differential_swing(differential_swing), .lock_output_pin(lock_output_pin),
   .sleep_active(sleep_active), .cal_busy(cal_busy));

/* dv/testbench.sv */
// Self-checking testbench of the clock generator control block
// Assumes the oscillator runs as an enable on every cycle and a short wait timer
`timescale 1ns/10ps
module testbench;
   logic       clk;
   logic       nrst;
   logic       por;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic       osc_tick;
   logic       ref_tick;
   logic       ref_present;
   wire  [7:0] rdata;
   wire        pd_feedback_tick;
   wire  [3:0] out_tick;
   wire  [3:0] driver_on;
   wire  [3:0] driver_termination_on;
   wire  [7:0] differential_swing;
   wire        lock_output_pin;
   wire        sleep_active;
   wire        cal_busy;
   int         n_mismatch;
   int         comparisons;
   int         ref_per;
   int         ref_cnt;
   int         cnt [5];

   clkgen_control #(.WAIT_CYCLES(20)) clkgen_control_inst (.clk(clk), .nrst(nrst), .por(por),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_tick(osc_tick),
      .ref_tick(ref_tick), .ref_present(ref_present), .pd_feedback_tick(pd_feedback_tick),
      .out_tick(out_tick), .driver_on(driver_on), .driver_termination_on(driver_termination_on),
      .differential_swing(differential_swing), .lock_output_pin(lock_output_pin),
      .sleep_active(sleep_active), .cal_busy(cal_busy));

   always #5 clk = ~clk;
   // Reference edges; period 0 keeps the reference silent
   always @(posedge clk) begin
      if (ref_per == 0 || ref_cnt >= ref_per - 1) ref_cnt <= 0;
      else ref_cnt <= ref_cnt + 1;
      ref_tick <= (ref_per != 0 && ref_cnt >= ref_per - 1);
   end
   // ****************
   // Shared tasks
   // ****************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
      comparisons++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      chk(d, e);
   endtask
   task automatic count(input int n);
      cnt = '{default: 0};
      repeat (n) begin
         @(posedge clk);
         #1;
         for (int i = 0; i < 4; i++) cnt[i] += out_tick[i];
         cnt[4] += pd_feedback_tick;
      end
   endtask
   // Cycles until cal_busy equals v, bounded by lim
   task automatic wait_busy(input logic v, input int lim, output int n);
      n = 0;
      while (cal_busy !== v && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_cal;
      int n;
      logic [7:0] s;
      wr_reg(8'h01, 8'h04);
      count(40);
      wait_busy(1'b1, 1, n);
      chk_rng(n, 1, 1);
      rd_reg(8'h30, s);
      chk(s & 8'h0E, 8'h04);
      @(posedge clk) ref_present <= 1'b1;
      wait_busy(1'b1, 20, n);
      chk_rng(n, 0, 19);
      wait_busy(1'b0, 40, n);
      chk_rng(n, 16, 16);
      repeat (40) @(posedge clk);
      rd_reg(8'h30, s);
      chk(s & 8'h0A, 8'h00);
      repeat (20) @(posedge clk);
      rd_reg(8'h30, s);
      chk(s & 8'h0A, 8'h08);
      $display("t_cal done");
   endtask
   task automatic t_defaults;
      rd_chk(8'h14, 8'h01);
      rd_chk(8'h1B, 8'h04);
      rd_chk(8'h23, 8'h0F);
      rd_chk(8'h1D, 8'h00);
      chk({4'h0, driver_on}, 8'h0F);
      rd_chk(8'h03, 8'h00);
      $display("t_defaults done");
   endtask
   task automatic t_regs;
      logic [7:0] a;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         a = 8'(8'h14 + 2 * i);
         d = {2'h0, 2'(i), i[0], ~i[0], 2'h1};
         wr_reg(a, 8'(8'h30 + i));
         rd_chk(a, 8'(8'h30 + i));
         wr_reg(a + 8'h01, d);
         #1 chk({7'h0, driver_termination_on[i]}, {7'h0, d[3]});
         chk({7'h0, driver_on[i]}, {7'h0, d[2]});
         chk({6'h0, differential_swing[2*i +: 2]}, {6'h0, d[5:4]});
         rd_chk(a + 8'h01, d & 8'hFE);
         rd_chk(a, 8'(8'h30 + i));
      end
      $display("t_regs done");
   endtask
   task automatic t_feedback;
      int e;
      for (int k = 0; k < 4; k++) begin
         wr_reg(8'h22, {4'h0, 2'(k), 2'h1});
         wr_reg(8'h23, 8'h04);
         wr_reg(8'h24, 8'h01);
         count(240);
         e = 240 / ((4 + k) * 2);
         chk_rng(cnt[4], e - 1, e + 1);
      end
      rd_chk(8'h24, 8'h00);
      rd_chk(8'h22, 8'h0C);
      $display("t_feedback done");
   endtask
   task automatic t_chan;
      int m;
      int t;
      wr_reg(8'h20, 8'h01);
      wr_reg(8'h21, 8'h19);
      wr_reg(8'h14, 8'h03);
      wr_reg(8'h16, 8'h00);
      wr_reg(8'h18, 8'h02);
      wr_reg(8'h1A, 8'h04);
      for (int i = 0; i < 4; i++) wr_reg(8'(8'h15 + 2 * i), 8'h05);
      count(168);
      chk_rng(cnt[0], 27, 29);
      chk_rng(cnt[1], 0, 0);
      chk_rng(cnt[2], 23, 25);
      chk_rng(cnt[3], 11, 13);
      // Staggered restarts leave channels one and two out of step until a sync
      wr_reg(8'h16, 8'h03);
      wr_reg(8'h15, 8'h05);
      wr_reg(8'h17, 8'h05);
      for (int p = 0; p < 2; p++) begin
         if (p == 1) wr_reg(8'h01, 8'h02);
         repeat (4) @(posedge clk);
         m = 0;
         t = 0;
         repeat (60) begin
            @(posedge clk);
            #1 m += (out_tick[0] !== out_tick[1]);
            t += out_tick[0];
         end
         if (p == 0) chk_rng(m, 1, 60);
         else chk_rng(m, 0, 0);
         chk_rng(t, 9, 11);
      end
      $display("t_chan done");
   endtask
   task automatic t_lock;
      int n;
      logic [7:0] s;
      logic [7:0] lo;
      logic [7:0] hi;
      wr_reg(8'h1D, 8'h06);
      wr_reg(8'h22, 8'h01);
      wr_reg(8'h23, 8'h02);
      wr_reg(8'h24, 8'h01);
      for (int p = 4; p < 6; p++) begin
         @(posedge clk) ref_per <= p;
         n = 0;
         while (lock_output_pin !== (p == 4) && n < 12000) begin
            @(posedge clk);
            #1 n++;
         end
         chk_rng(n, 0, 11999);
         rd_reg(8'h30, s);
         chk(s & 8'h01, {7'h0, p == 4});
         rd_reg(8'h1E, lo);
         rd_reg(8'h1F, hi);
         chk(hi & 8'h08, 8'h08);
         if (p == 4) chk_rng({hi[1:0], lo}, 0, 7);
         else chk_rng({hi[1:0], lo}, 8, 1023);
      end
      $display("t_lock done");
   endtask
   task automatic t_sleep;
      wr_reg(8'h02, 8'h03);
      #1 chk({7'h0, sleep_active}, 8'h01);
      count(20);
      chk_rng(cnt[0] + cnt[2], 0, 0);
      chk({4'h0, driver_on}, 8'h00);
      wr_reg(8'h02, 8'h00);
      #1 chk({4'h0, driver_on}, 8'h0F);
      $display("t_sleep done");
   endtask
   task automatic t_resets;
      int n;
      wr_reg(8'h14, 8'h22);
      wr_reg(8'h00, 8'hA2);
      wr_reg(8'h16, 8'h55);
      repeat (2) @(posedge clk);
      rd_chk(8'h16, 8'h01);
      rd_chk(8'h14, 8'h01);
      rd_chk(8'h00, 8'h20);
      wr_reg(8'h1D, 8'h0E);
      rd_chk(8'h1D, 8'h0E);
      @(posedge clk) nrst <= 1'b0;
      @(posedge clk) nrst <= 1'b1;
      rd_chk(8'h1D, 8'h00);
      wr_reg(8'h01, 8'h04);
      wait_busy(1'b1, 5, n);
      chk_rng(n, 0, 4);
      $display("t_resets done");
   endtask
   task automatic finish_test;
      $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      por = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      osc_tick = 1'b1;
      ref_present = 1'b0;
      ref_per = 0;
      ref_tick = 1'b0;
      ref_cnt = 0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      por <= 1'b0;
      t_cal;
      t_defaults;
      t_regs;
      t_feedback;
      t_chan;
      t_lock;
      t_sleep;
      t_resets;
      finish_test;
   end
   // Lock search dominates the run; this allows about four times the expected span
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      finish_test;
   end
endmodule
